// [irq_ctrl_map.vh]
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH

// Register offsets.
`define OFS_INTERRUPT_CONTROL 8'h0b
`define OFS_PERIPHERAL_FLAGS 8'h0c
`define OFS_PERIPHERAL_ENABLES 8'h8c
`define OFS_IRQ_CONFIG 8'h81

// Fields of interrupt_control.
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_PERIPHERAL_IRQ_ENABLE 6
`define BIT_TIMER_OVF_IRQ_ENABLE 5
`define BIT_EXT_PIN_IRQ_ENABLE 4
`define BIT_PORT_CHANGE_IRQ_ENABLE 3
`define BIT_TIMER_OVF_FLAG 2
`define BIT_EXT_PIN_FLAG 1
`define BIT_PORT_CHANGE_FLAG 0

// Fields of the configuration register.
`define BIT_EXT_EDGE_SELECT 6

// Peripheral flag and enable layout; bit 3 is unused.
`define PERIPH_IMPL_MASK 8'hf7

// Reset values.
`define RST_INTERRUPT_CONTROL 8'h00
`define RST_PERIPHERAL 8'h00
`define RST_IRQ_CONFIG 8'hff

// Interrupt vector.
`define IRQ_VECTOR 13'h0004

// Quarter phases per instruction cycle.
`define QUARTER_COUNT 4

`endif

// [edge_catch.v]
`timescale 1ns/10ps
`default_nettype none

// Detects a selected edge of one synchronous input.
module edge_catch (
  input wire clk_sys,
  input wire resetn,
  input wire sig_in,
  input wire rise_sel,
  output wire edge_pulse
);

  reg sig_prev_reg;
  reg armed_reg;

  // The first edge after reset only loads the history, so a pin already high
  // or low when reset ends does not look like an edge.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sig_prev_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      sig_prev_reg <= sig_in;
      armed_reg <= 1'b1;
    end
  end

  assign edge_pulse = armed_reg
    & (rise_sel ? (sig_in & ~sig_prev_reg) : (~sig_in & sig_prev_reg));

endmodule

`default_nettype wire

// [irq_ctrl.v]
// Overview of operation
// - Ten sources: ext pin, timer, port change and seven peripheral events.
// - Global enable in control bit 7 lets unmasked requests reach the core.
// - Every reset clears the global enable.
// - Return-from-interrupt pops the return address and sets the global enable.
// - Accepting an interrupt clears global enable, pushes return address, vectors to 0004h.
// - Flags set on their events regardless of any enable.
// - Pin and port-change latency is three to four instruction cycles; here irq_take follows within two.
// - After global enable is cleared, next cycle ignores interrupts; a clearing instruction also runs a no-op, a register write does not.
// - External pin edge: rising when edge select bit 6 is set, else falling.
// - A valid pin edge sets control bit 1; its enable gates the request.
// - Pin interrupt wakes from sleep if enabled; global enable decides the branch.
// - Timer wrap FFh to 00h sets control bit 2; enabled by bit 5.
// - Change on upper port bits 7..4 sets control bit 0; enabled by bit 3.
// - A change coinciding with the port read may miss setting the flag.
// - Pin flag sampled every first quarter phase; may set from fourth through first.
// - Peripheral flags and enables pair bit for bit; bit 3 unused.
// - Power-up clears all of control including bit 0; other resets keep bit 0.
// - Only the return address is saved by hardware on entry.
// - Any enabled flag wakes the core even with global enable clear.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctrl_map.vh"

module irq_ctrl (
  input wire clk_sys,
  input wire resetn,
  input wire por_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire ext_irq_pin,
  input wire [3:0] upper_port_pins,
  input wire port_read,
  input wire tick_wrap,
  input wire [7:0] periph_events,
  input wire [1:0] quarter_phase,
  input wire return_exec,
  input wire global_clear_exec,
  input wire irq_ack,
  input wire [12:0] pc_current,
  output wire irq_request,
  output wire wake_request,
  output reg irq_take,
  output reg force_nop,
  output reg [12:0] vector_pc,
  output reg stack_push,
  output reg [12:0] stack_push_data,
  output reg stack_pop
);

  localparam [1:0] PH_FIRST = 2'd0;
  localparam [1:0] PH_SECOND = 2'd1;
  localparam [1:0] PH_FOURTH = 2'd3;

  reg [7:0] ctrl_reg;
  reg [7:0] ctrl_next;
  reg [7:0] pflag_reg;
  reg [7:0] pflag_next;
  reg [7:0] pen_reg;
  reg [7:0] cfg_reg;
  reg port_bit0_reg;
  reg [3:0] port_latch_reg;
  reg ext_pend_reg;
  reg ext_sampled_reg;
  reg nop_hold_reg;
  reg por_seen_reg;
  wire ext_edge;
  wire port_change;
  wire core_hit;
  wire periph_hit;
  wire any_enabled;
  wire wr_ctrl;
  wire wr_pflag;

  ////////////////////////////////////////////////////////////////////////////
  // Event detection.

  edge_catch ext_edge_inst (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .sig_in(ext_irq_pin),
    .rise_sel(cfg_reg[`BIT_EXT_EDGE_SELECT]),
    .edge_pulse(ext_edge)
  );

  // The port is compared against the value latched at the last read or detected change, so a
  // change landing on a read in the second phase is absorbed into the latch.
  assign port_change = (upper_port_pins != port_latch_reg)
    & ~(port_read & (quarter_phase == PH_SECOND));

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      port_latch_reg <= 4'h0;
    end else if (port_read || port_change) begin
      port_latch_reg <= upper_port_pins;
    end
  end

  // Pin edges are held until the window from the fourth through first phase.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_pend_reg <= 1'b0;
    end else if (quarter_phase == PH_FOURTH || quarter_phase == PH_FIRST) begin
      ext_pend_reg <= 1'b0;
    end else if (ext_edge) begin
      ext_pend_reg <= 1'b1;
    end
  end

  wire ext_set = (ext_edge || ext_pend_reg)
    && (quarter_phase == PH_FOURTH || quarter_phase == PH_FIRST);

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  assign wr_ctrl = reg_wr && (reg_addr == `OFS_INTERRUPT_CONTROL);
  assign wr_pflag = reg_wr && (reg_addr == `OFS_PERIPHERAL_FLAGS);

  always @* begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = reg_wdata;
    end
    if (return_exec) begin
      ctrl_next[`BIT_GLOBAL_IRQ_ENABLE] = 1'b1;
    end
    if (irq_take) begin
      ctrl_next[`BIT_GLOBAL_IRQ_ENABLE] = 1'b0;
    end
    // Hardware sets win over a software clear in the same cycle.
    if (ext_set) begin
      ctrl_next[`BIT_EXT_PIN_FLAG] = 1'b1;
    end
    if (tick_wrap) begin
      ctrl_next[`BIT_TIMER_OVF_FLAG] = 1'b1;
    end
    if (port_change) begin
      ctrl_next[`BIT_PORT_CHANGE_FLAG] = 1'b1;
    end
  end

  always @* begin
    pflag_next = pflag_reg;
    if (wr_pflag) begin
      pflag_next = reg_wdata;
    end
    pflag_next = (pflag_next | periph_events) & `PERIPH_IMPL_MASK;
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= `RST_INTERRUPT_CONTROL;
      pflag_reg <= `RST_PERIPHERAL;
      pen_reg <= `RST_PERIPHERAL;
      cfg_reg <= `RST_IRQ_CONFIG;
      por_seen_reg <= 1'b0;
    end else begin
      por_seen_reg <= 1'b1;
      // On the first edge after a non-power-up reset, restore bit 0.
      if (!por_seen_reg && por_n) begin
        ctrl_reg <= {ctrl_next[7:1], port_bit0_reg | ctrl_next[0]};
      end else begin
        ctrl_reg <= ctrl_next;
      end
      pflag_reg <= pflag_next;
      if (reg_wr && reg_addr == `OFS_PERIPHERAL_ENABLES) begin
        pen_reg <= reg_wdata & `PERIPH_IMPL_MASK;
      end
      if (reg_wr && reg_addr == `OFS_IRQ_CONFIG) begin
        cfg_reg <= reg_wdata;
      end
    end
  end

  // Keeps the port-change flag through resets other than power-up.
  always @(posedge clk_sys) begin
    if (resetn) begin
      port_bit0_reg <= ctrl_next[`BIT_PORT_CHANGE_FLAG];
    end else if (!por_n) begin
      port_bit0_reg <= 1'b0;
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_INTERRUPT_CONTROL: reg_rdata <= ctrl_reg;
        `OFS_PERIPHERAL_FLAGS: reg_rdata <= pflag_reg;
        `OFS_PERIPHERAL_ENABLES: reg_rdata <= pen_reg;
        `OFS_IRQ_CONFIG: reg_rdata <= cfg_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request, wake and vectoring.

  // The pin flag only counts once it has been sampled at a first phase.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_sampled_reg <= 1'b0;
    end else if (quarter_phase == PH_FIRST) begin
      ext_sampled_reg <= ctrl_reg[`BIT_EXT_PIN_FLAG];
    end else if (!ctrl_reg[`BIT_EXT_PIN_FLAG]) begin
      ext_sampled_reg <= 1'b0;
    end
  end

  assign core_hit = (ext_sampled_reg & ctrl_reg[`BIT_EXT_PIN_IRQ_ENABLE])
    | (ctrl_reg[`BIT_TIMER_OVF_FLAG] & ctrl_reg[`BIT_TIMER_OVF_IRQ_ENABLE])
    | (ctrl_reg[`BIT_PORT_CHANGE_FLAG] & ctrl_reg[`BIT_PORT_CHANGE_IRQ_ENABLE]);
  assign periph_hit = |(pflag_reg & pen_reg);
  assign any_enabled = core_hit | periph_hit;
  assign wake_request = any_enabled;
  assign irq_request = ctrl_reg[`BIT_GLOBAL_IRQ_ENABLE] & ~nop_hold_reg & ~irq_take
    & (core_hit | (ctrl_reg[`BIT_PERIPHERAL_IRQ_ENABLE] & periph_hit));

  // A write or instruction that drops the global enable masks the next cycle.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      nop_hold_reg <= 1'b0;
      force_nop <= 1'b0;
    end else begin
      nop_hold_reg <= global_clear_exec
        | (wr_ctrl & ~reg_wdata[`BIT_GLOBAL_IRQ_ENABLE] & ctrl_reg[`BIT_GLOBAL_IRQ_ENABLE]);
      force_nop <= global_clear_exec;
    end
  end

  // Entry pushes only the return address and jumps to the vector.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_take <= 1'b0;
      stack_push <= 1'b0;
      stack_push_data <= 13'h0000;
      vector_pc <= 13'h0000;
      stack_pop <= 1'b0;
    end else begin
      irq_take <= irq_request & irq_ack;
      stack_push <= irq_request & irq_ack;
      stack_pop <= return_exec;
      if (irq_request && irq_ack) begin
        stack_push_data <= pc_current;
        vector_pc <= `IRQ_VECTOR;
      end
    end
  end

endmodule

`default_nettype wire

// [irq_ctrl_props.sv]
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl_props (
  input wire clk_sys,
  input wire resetn,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire irq_ack,
  input wire irq_request,
  input wire wake_request,
  input wire irq_take,
  input wire force_nop,
  input wire [12:0] vector_pc,
  input wire stack_push,
  input wire stack_pop,
  input wire return_exec,
  input wire global_clear_exec
);
  default clocking
    @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  chk_take_vector: assert property (irq_take |-> stack_push && vector_pc == 13'h0004)
    else $error("entry without push or wrong vector");
  chk_take_cause: assert property (irq_take |-> $past(irq_request && irq_ack))
    else $error("entry without request at boundary");
  chk_take_mask: assert property (irq_take |-> ##2 !irq_request)
    else $error("request stays after entry");
  chk_take_pulse: assert property (irq_take |=> !irq_take)
    else $error("entry pulse too long");
  chk_nop_mask: assert property (global_clear_exec |=> force_nop && !irq_request)
    else $error("no masked no-op after enable clear");
  chk_pop_return: assert property (return_exec |=> stack_pop)
    else $error("return does not pop");
  chk_wake_req: assert property (irq_request |-> wake_request)
    else $error("request without wake");
  chk_reset_quiet: assert property ($rose(resetn) |-> !irq_take && !stack_push && !stack_pop)
    else $error("activity right after reset");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  cover property (irq_take);
  cover property (stack_pop);
  cover property (force_nop);
endmodule
bind irq_ctrl irq_ctrl_props irq_ctrl_props_inst (.clk_sys, .resetn, .reg_rd, .reg_rdata,
  .irq_ack, .irq_request, .wake_request, .irq_take, .force_nop, .vector_pc, .stack_push,
  .stack_pop, .return_exec, .global_clear_exec);
`default_nettype wire

// [core_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Core sequencer: quarter phases, program counter and a one-deep return stack.
module core_model (
  input wire clk_sys,
  input wire resetn,
  input wire irq_take,
  input wire [12:0] vector_pc,
  input wire stack_push,
  input wire [12:0] stack_push_data,
  input wire stack_pop,
  output var logic [1:0] quarter_phase,
  output wire logic irq_ack,
  output var logic [12:0] pc_current
);
  logic [12:0] saved_pc;
  assign irq_ack = (quarter_phase == 2'd3);
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      quarter_phase <= 2'd0;
      pc_current <= 13'h0000;
      saved_pc <= 13'h0000;
    end else begin
      quarter_phase <= quarter_phase + 2'd1;
      if (stack_push)
        saved_pc <= stack_push_data;
      if (irq_take)
        pc_current <= vector_pc;
      else if (stack_pop)
        pc_current <= saved_pc;
      else if (quarter_phase == 2'd3)
        pc_current <= pc_current + 13'd1;
    end
  end
endmodule
`default_nettype wire

// [irq_ctrl_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module irq_ctrl_bench;
  logic clk_sys, resetn, por_n, reg_wr, reg_rd, ext_irq_pin, port_read, tick_wrap;
  logic return_exec, global_clear_exec, irq_ack, irq_request, wake_request, irq_take;
  logic force_nop, stack_push, stack_pop;
  logic [7:0] reg_addr, reg_wdata, periph_events, reg_rdata;
  logic [3:0] upper_port_pins;
  logic [1:0] quarter_phase;
  logic [12:0] pc_current, vector_pc, stack_push_data;
  int miscompares, num_checks, cycles;
  irq_ctrl irq_ctrl_inst (.clk_sys, .resetn, .por_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ext_irq_pin, .upper_port_pins, .port_read, .tick_wrap, .periph_events,
    .quarter_phase, .return_exec, .global_clear_exec, .irq_ack, .pc_current, .irq_request,
    .wake_request, .irq_take, .force_nop, .vector_pc, .stack_push, .stack_push_data, .stack_pop);
  core_model core_model_inst (.clk_sys, .resetn, .irq_take, .vector_pc, .stack_push,
    .stack_push_data, .stack_pop, .quarter_phase, .irq_ack, .pc_current);
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    step(1);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    step(1);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    `CHK(reg_rdata, e)
    step(1);
  endtask
  task automatic wait_take;
    for (int i = 0; i < 40 && irq_take !== 1'b1; i++) begin
      @(negedge clk_sys);
    end
    `CHK(irq_take, 1'b1)
    `CHK(vector_pc, 13'h0004)
    `CHK(stack_push, 1'b1)
    step(1);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_sim;
    end
  end
  initial begin
    {resetn, por_n, reg_wr, reg_rd, ext_irq_pin, port_read, tick_wrap} = '0;
    {return_exec, global_clear_exec, reg_addr, reg_wdata, periph_events, upper_port_pins} = '0;
    step(10);
    resetn <= 1'b1;
    por_n <= 1'b1;
    step(1);
    rd(8'h0b, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h8c, 8'h00);
    rd(8'h81, 8'hff);
    rd(8'h55, 8'h00);
    wr(8'h8c, 8'hff);
    rd(8'h8c, 8'hf7);
    periph_events <= 8'hff;
    tick_wrap <= 1'b1;
    step(1);
    periph_events <= 8'h00;
    tick_wrap <= 1'b0;
    rd(8'h0c, 8'hf7);
    rd(8'h0b, 8'h04);
    wr(8'h0c, 8'h00);
    wr(8'h8c, 8'h01);
    wr(8'h0b, 8'hc0);
    periph_events <= 8'h01;
    step(1);
    periph_events <= 8'h00;
    wait_take;
    rd(8'h0b, 8'h40);
    wr(8'h0b, 8'ha0);
    tick_wrap <= 1'b1;
    step(1);
    tick_wrap <= 1'b0;
    wait_take;
    rd(8'h0b, 8'h24);
    wr(8'h0b, 8'h20);
    return_exec <= 1'b1;
    step(1);
    return_exec <= 1'b0;
    rd(8'h0b, 8'ha0);
    global_clear_exec <= 1'b1;
    wr(8'h0b, 8'h00);
    global_clear_exec <= 1'b0;
    ext_irq_pin <= 1'b1;
    step(8);
    rd(8'h0b, 8'h02);
    wr(8'h0b, 8'h90);
    wr(8'h81, 8'hbf);
    ext_irq_pin <= 1'b0;
    wait_take;
    rd(8'h0b, 8'h12);
    `CHK(wake_request, 1'b1)
    wr(8'h0b, 8'h00);
    ext_irq_pin <= 1'b1;
    step(8);
    rd(8'h0b, 8'h00);
    port_read <= 1'b1;
    step(1);
    port_read <= 1'b0;
    upper_port_pins <= 4'h8;
    step(4);
    rd(8'h0b, 8'h01);
    upper_port_pins <= 4'h0;
    step(2);
    resetn <= 1'b0;
    step(2);
    resetn <= 1'b1;
    step(1);
    rd(8'h0b, 8'h01);
    por_n <= 1'b0;
    resetn <= 1'b0;
    step(2);
    resetn <= 1'b1;
    por_n <= 1'b1;
    step(1);
    rd(8'h0b, 8'h00);
    end_sim;
  end
endmodule
`default_nettype wire
